// [hdl/qdc_cfg.svh]
// Constants for the quad converter control block
`ifndef QDC_CFG_SVH
`define QDC_CFG_SVH

// ==========================================================
// Slave address: fixed top five bits, low two from pins
`define QDC_SLAVE_ADDR_TOP 5'h13
`define QDC_RW_BIT 1'b0

// ==========================================================
// Control byte field positions
`define QDC_EXT_HI_BIT 7
`define QDC_EXT_LO_BIT 6
`define QDC_MODE_HI_BIT 5
`define QDC_MODE_LO_BIT 4
`define QDC_SEL_HI_BIT 2
`define QDC_SEL_LO_BIT 1
`define QDC_PD_FLAG_BIT 0

// ==========================================================
// Update mode codes
`define QDC_MODE_TEMP 2'h0
`define QDC_MODE_BOTH 2'h1
`define QDC_MODE_SYNC 2'h2
`define QDC_MODE_BCAST 2'h3

// ==========================================================
// Data layout and reset values
`define QDC_PD_MODE_HI 7
`define QDC_PD_MODE_LO 6
`define QDC_LOW_NIBBLE_HI 7
`define QDC_LOW_NIBBLE_LO 4
`define QDC_STORE_RESET 14'h0000
`define QDC_BYTE_RESET 8'h00
`define QDC_BITS_PER_BYTE 4'h8

`endif

// [hdl/qdc_pkg.sv]
// Types shared by the quad converter control block
package qdc_pkg;

    // ==========================================================
    // Register update operation handed to the channel bank
    typedef enum logic [2:0] {
        QDC_OP_NONE = 3'b000,
        QDC_OP_TEMP = 3'b001,
        QDC_OP_BOTH = 3'b010,
        QDC_OP_SYNC = 3'b011,
        QDC_OP_LOADALL = 3'b100,
        QDC_OP_BCAST = 3'b101
    } qdc_op_t;

    // ==========================================================
    // Receive phase of a bus write
    typedef enum logic [2:0] {
        QDC_ST_IDLE = 3'b000,
        QDC_ST_ADDR = 3'b001,
        QDC_ST_CTRL = 3'b010,
        QDC_ST_HIGH = 3'b011,
        QDC_ST_LOW = 3'b100,
        QDC_ST_IGNORE = 3'b101
    } qdc_state_t;

endpackage : qdc_pkg

// [hdl/qdc_sync.sv]
// Two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps

module qdc_sync #(
    parameter int W = 1,
    // Idle level of each pin, so the release of reset shows no false edge
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Pins in, synchronised levels out
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    // ==========================================================
    // First stage feeds only the second stage
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            meta_reg <= RST_VAL;
            sync_reg <= RST_VAL;
        end else begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
        end
    end

    assign o_sync = sync_reg;

endmodule : qdc_sync

// [hdl/qdc_regbank.sv]
// Per-channel temporary and converter stores with readback
`timescale 1ns/1ps
`include "qdc_cfg.svh"

module qdc_regbank #(
    parameter int CH = 4,
    parameter int W = 14,
    parameter int SW = 2
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Update request
    input wire qdc_pkg::qdc_op_t i_op,
    input wire logic [SW-1:0] i_sel,
    input wire logic [W-1:0] i_word,
    input wire logic i_load_all,
    // Readback
    input wire logic [SW-1:0] i_rd_sel,
    output logic [W-1:0] o_rd_data,
    // Store contents
    output logic [W-1:0] o_temp [CH],
    output logic [W-1:0] o_conv [CH]
);
    import qdc_pkg::*;

    logic [W-1:0] temp_reg [CH];
    logic [W-1:0] conv_reg [CH];
    logic [W-1:0] rd_reg;

    // ==========================================================
    // Stores; a bus update on the same edge overrides the load pin only in the converter stores it writes
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            for (int i = 0; i < CH; i++) begin
                temp_reg[i] <= `QDC_STORE_RESET;
                conv_reg[i] <= `QDC_STORE_RESET;
            end
        end else begin
            if (i_load_all) begin
                for (int i = 0; i < CH; i++) begin
                    conv_reg[i] <= temp_reg[i];
                end
            end
            unique case (i_op)
                QDC_OP_NONE: begin
                end
                QDC_OP_TEMP: begin
                    temp_reg[i_sel] <= i_word;
                end
                QDC_OP_BOTH: begin
                    temp_reg[i_sel] <= i_word;
                    conv_reg[i_sel] <= i_word;
                end
                QDC_OP_SYNC: begin
                    temp_reg[i_sel] <= i_word;
                    for (int i = 0; i < CH; i++) begin
                        conv_reg[i] <= (SW'(i) == i_sel) ? i_word : temp_reg[i];
                    end
                end
                QDC_OP_LOADALL: begin
                    for (int i = 0; i < CH; i++) begin
                        conv_reg[i] <= temp_reg[i];
                    end
                end
                QDC_OP_BCAST: begin
                    for (int i = 0; i < CH; i++) begin
                        temp_reg[i] <= i_word;
                        conv_reg[i] <= i_word;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // Registered readback of the temporary store
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            rd_reg <= `QDC_STORE_RESET;
        end else begin
            rd_reg <= temp_reg[i_rd_sel];
        end
    end

    assign o_rd_data = rd_reg;
    assign o_temp = temp_reg;
    assign o_conv = conv_reg;

endmodule : qdc_regbank

// [hdl/qdc_ctrl.sv]
// Bus receive, control-byte decode and update logic of a quad converter
`timescale 1ns/1ps
`include "qdc_cfg.svh"

module qdc_ctrl (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // Two-wire bus
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe,
    // Address-select and load pins
    input wire logic [1:0] i_slave_addr_pins,
    input wire logic [1:0] i_ext_addr_pins,
    input wire logic i_load_strobe_pin,
    // Readback
    input wire logic [1:0] i_readback_sel,
    output logic [13:0] o_readback,
    // Channel outputs: powerdown mode in 13:12, code in 11:0
    output logic [13:0] o_output_channel_a,
    output logic [13:0] o_output_channel_b,
    output logic [13:0] o_output_channel_c,
    output logic [13:0] o_output_channel_d
);
    import qdc_pkg::*;

    // ==========================================================
    // Helpers
    function automatic logic [13:0] form_word(input logic [7:0] hi, input logic [7:0] lo,
                                              input logic pd);
        logic [13:0] w;
        if (pd) begin
            w = {hi[`QDC_PD_MODE_HI:`QDC_PD_MODE_LO], 12'h000};
        end else begin
            w = {2'h0, hi, lo[`QDC_LOW_NIBBLE_HI:`QDC_LOW_NIBBLE_LO]};
        end
        return w;
    endfunction : form_word

    function automatic qdc_op_t decode_op(input logic [7:0] ctrl, input logic ext_ok);
        logic [1:0] mode;
        qdc_op_t op;
        mode = {ctrl[`QDC_MODE_HI_BIT], ctrl[`QDC_MODE_LO_BIT]};
        op = QDC_OP_NONE;
        if (mode == `QDC_MODE_BCAST) begin
            op = ctrl[`QDC_SEL_HI_BIT] ? QDC_OP_BCAST : QDC_OP_LOADALL;
        end else if (ext_ok) begin
            unique case (mode)
                `QDC_MODE_TEMP: op = QDC_OP_TEMP;
                `QDC_MODE_BOTH: op = QDC_OP_BOTH;
                `QDC_MODE_SYNC: op = QDC_OP_SYNC;
                default: op = QDC_OP_NONE;
            endcase
        end
        return op;
    endfunction : decode_op

    // ==========================================================
    // Pin synchronisers
    logic [6:0] pins_sync;
    logic scl_s;
    logic sda_s;
    logic load_s;
    logic [1:0] ext_s;
    logic [1:0] sa_s;

    // Bus clock and data idle high; resetting them low would fake a clock rise
    qdc_sync #(
        .W(7),
        .RST_VAL(7'h60)
    ) u_sync (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_async({i_scl, i_sda, i_load_strobe_pin, i_ext_addr_pins, i_slave_addr_pins}),
        .o_sync(pins_sync)
    );

    assign scl_s = pins_sync[6];
    assign sda_s = pins_sync[5];
    assign load_s = pins_sync[4];
    assign ext_s = pins_sync[3:2];
    assign sa_s = pins_sync[1:0];

    // ==========================================================
    // Edge detection on the synchronised levels
    logic scl_d_reg;
    logic sda_d_reg;
    logic load_d_reg;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
            load_d_reg <= 1'b0;
        end else begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
            load_d_reg <= load_s;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic load_edge;

    assign scl_rise = scl_s & ~scl_d_reg;
    assign scl_fall = ~scl_s & scl_d_reg;
    assign bus_start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    assign bus_stop = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
    // The load pin is edge sensitive and ignores the bus clock entirely
    assign load_edge = load_s & ~load_d_reg;

    // ==========================================================
    // Receive sequencing
    qdc_state_t state_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic in_ack_reg;
    logic upd_pend_reg;
    logic byte_done;
    logic addr_hit;
    logic ack_fall;

    assign byte_done = scl_fall & (bit_cnt_reg == `QDC_BITS_PER_BYTE) & ~in_ack_reg
                       & (state_reg != QDC_ST_IDLE) & (state_reg != QDC_ST_IGNORE);
    assign addr_hit = (shift_reg[7:1] == {`QDC_SLAVE_ADDR_TOP, sa_s})
                      & (shift_reg[0] == `QDC_RW_BIT);
    assign ack_fall = scl_fall & in_ack_reg;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            state_reg <= QDC_ST_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= `QDC_BYTE_RESET;
        end else if (bus_start) begin
            state_reg <= QDC_ST_ADDR;
            bit_cnt_reg <= 4'h0;
        end else if (bus_stop) begin
            state_reg <= QDC_ST_IDLE;
            bit_cnt_reg <= 4'h0;
        end else begin
            if (scl_rise && bit_cnt_reg != `QDC_BITS_PER_BYTE) begin
                shift_reg <= {shift_reg[6:0], sda_s};
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (ack_fall) begin
                bit_cnt_reg <= 4'h0;
            end
            if (byte_done) begin
                unique case (state_reg)
                    QDC_ST_ADDR: state_reg <= addr_hit ? QDC_ST_CTRL : QDC_ST_IGNORE;
                    QDC_ST_CTRL: state_reg <= QDC_ST_HIGH;
                    QDC_ST_HIGH: state_reg <= QDC_ST_LOW;
                    QDC_ST_LOW: state_reg <= QDC_ST_HIGH;
                    default: state_reg <= QDC_ST_IGNORE;
                endcase
            end
        end
    end

    // ==========================================================
    // Byte stores written by the master
    logic [7:0] ctrl_reg;
    logic [7:0] msb_reg;
    logic [7:0] lsb_reg;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            ctrl_reg <= `QDC_BYTE_RESET;
            msb_reg <= `QDC_BYTE_RESET;
            lsb_reg <= `QDC_BYTE_RESET;
        end else if (byte_done) begin
            if (state_reg == QDC_ST_CTRL) begin
                ctrl_reg <= shift_reg;
            end
            if (state_reg == QDC_ST_HIGH) begin
                msb_reg <= shift_reg;
            end
            if (state_reg == QDC_ST_LOW) begin
                lsb_reg <= shift_reg;
            end
        end
    end

    // ==========================================================
    // Acknowledge drive and pending update
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            in_ack_reg <= 1'b0;
            upd_pend_reg <= 1'b0;
        end else if (bus_start || bus_stop) begin
            in_ack_reg <= 1'b0;
            upd_pend_reg <= 1'b0;
        end else if (byte_done) begin
            in_ack_reg <= (state_reg != QDC_ST_ADDR) | addr_hit;
            upd_pend_reg <= (state_reg == QDC_ST_LOW);
        end else if (ack_fall) begin
            in_ack_reg <= 1'b0;
            upd_pend_reg <= 1'b0;
        end
    end

    // Open drain: only ever pulls low
    assign o_sda_out = 1'b0;
    assign o_sda_oe = in_ack_reg;

    // ==========================================================
    // Update decode, fired on the falling clock that ends the ack
    logic upd_fire;
    logic ext_ok;
    logic [13:0] new_word;
    qdc_op_t upd_op;

    assign upd_fire = ack_fall & upd_pend_reg;
    assign ext_ok = ({ctrl_reg[`QDC_EXT_HI_BIT], ctrl_reg[`QDC_EXT_LO_BIT]} == ext_s);
    assign new_word = form_word(msb_reg, lsb_reg, ctrl_reg[`QDC_PD_FLAG_BIT]);
    assign upd_op = upd_fire ? decode_op(ctrl_reg, ext_ok) : QDC_OP_NONE;

    // ==========================================================
    // Channel stores
    logic [13:0] temp_w [4];
    logic [13:0] conv_w [4];

    qdc_regbank #(
        .CH(4),
        .W(14),
        .SW(2)
    ) u_bank (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_op(upd_op),
        .i_sel({ctrl_reg[`QDC_SEL_HI_BIT], ctrl_reg[`QDC_SEL_LO_BIT]}),
        .i_word(new_word),
        .i_load_all(load_edge),
        .i_rd_sel(i_readback_sel),
        .o_rd_data(o_readback),
        .o_temp(temp_w),
        .o_conv(conv_w)
    );

    assign o_output_channel_a = conv_w[0];
    assign o_output_channel_b = conv_w[1];
    assign o_output_channel_c = conv_w[2];
    assign o_output_channel_d = conv_w[3];

    // ==========================================================
    // Checks
    logic [1:0] sel_w;
    assign sel_w = {ctrl_reg[`QDC_SEL_HI_BIT], ctrl_reg[`QDC_SEL_LO_BIT]};

    sequence s_ack_end;
        in_ack_reg && scl_fall && upd_pend_reg;
    endsequence

    sequence s_addr_ok;
        byte_done && state_reg == QDC_ST_ADDR && addr_hit;
    endsequence

    AST_UPDATE_ONLY_AT_ACK: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        (upd_op != QDC_OP_NONE) |-> $past(in_ack_reg) && !scl_s && $past(scl_s))
        else $error("Update fired outside the ack falling edge");

    AST_ADDR_ACKED: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        s_addr_ok |=> o_sda_oe && state_reg == QDC_ST_CTRL)
        else $error("Matching address not acknowledged");

    AST_MODE_TEMP_HOLDS_OUTPUT: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        (upd_op == QDC_OP_TEMP && !load_edge) |=> $stable(o_output_channel_a)
            && $stable(o_output_channel_d) && temp_w[sel_w] == $past(new_word))
        else $error("Temp-only update changed an output");

    AST_MODE_BOTH_WRITES: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        (s_ack_end ##0 (upd_op == QDC_OP_BOTH)) |=> conv_w[sel_w] == $past(new_word))
        else $error("Mode 01 did not load the converter store");

    AST_SYNC_OTHERS: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        (upd_op == QDC_OP_SYNC && sel_w != 2'h3) |=> o_output_channel_d == $past(temp_w[3]))
        else $error("Synchronous update missed another channel");

    AST_BCAST_ALL: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        (upd_op == QDC_OP_BCAST) |=> o_output_channel_b == $past(new_word)
            && o_output_channel_c == $past(new_word))
        else $error("Broadcast data not loaded into all channels");

    AST_EXT_MISMATCH: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        (upd_fire && !ext_ok && !ctrl_reg[`QDC_MODE_HI_BIT]) |-> upd_op == QDC_OP_NONE)
        else $error("Write acted on a foreign extended address");

    AST_PD_ZERO_CODE: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        ctrl_reg[`QDC_PD_FLAG_BIT] |-> new_word[11:0] == 12'h000
            && new_word[13:12] == msb_reg[7:6])
        else $error("Powerdown word carries code bits");

    AST_LOW_NIBBLE: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        !ctrl_reg[`QDC_PD_FLAG_BIT] |-> new_word[3:0] == lsb_reg[7:4]
            && new_word[11:4] == msb_reg)
        else $error("Data word layout wrong");

    AST_LOAD_PIN: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        (load_edge && upd_op == QDC_OP_NONE) |=> o_output_channel_d == $past(temp_w[3])
            && o_output_channel_a == $past(temp_w[0]))
        else $error("Load pin edge did not load converters");

    AST_RESET_CLEARS: assert property (
        @(posedge i_ref_clk)
        i_rst |=> o_output_channel_a == 14'h0000 && temp_w[2] == 14'h0000
            && o_readback == 14'h0000)
        else $error("Reset did not clear stores");

endmodule : qdc_ctrl

// [tb/qdc_bus_master.sv]
// Two-wire bus master model that drives write frames into the converter block
`timescale 1ns/1ps

module qdc_bus_master (
    // Reference clock and sensed data line
    input wire logic i_ref_clk,
    input wire logic i_sda_line,
    // Driven bus pins, released high
    output logic o_scl,
    output logic o_sda
);

    // ==========================================================
    // Idle bus: both lines released, clock stands still
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end

    // Every pin change lands a fixed step after a reference edge
    task automatic tick(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask : tick

    task automatic start();
        o_sda = 1'b0;
        tick(4);
        o_scl = 1'b0;
        tick(1);
    endtask : start

    task automatic stop();
        o_sda = 1'b0;
        tick(3);
        o_scl = 1'b1;
        tick(4);
        o_sda = 1'b1;
        tick(4);
    endtask : stop

    // ==========================================================
    // One byte, top bit first, then the acknowledge slot
    task automatic put_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            o_sda = b[i];
            tick(3);
            o_scl = 1'b1;
            tick(4);
            o_scl = 1'b0;
            tick(1);
        end
        // Data line released so the pull-up shows a missing acknowledge
        o_sda = 1'b1;
        tick(3);
        o_scl = 1'b1;
        tick(2);
        ack = ~i_sda_line;
        tick(2);
        o_scl = 1'b0;
        tick(1);
    endtask : put_byte

endmodule : qdc_bus_master

// [tb/qdc_ctrl_tb.sv]
// Self-checking bench for the quad converter control block
`timescale 1ns/1ps
`include "qdc_cfg.svh"

module qdc_ctrl_tb;
    import qdc_pkg::*;

    // ==========================================================
    // Clock, pins and expected stores
    localparam logic [1:0] SLV_PINS = 2'h2;
    localparam logic [1:0] EXT_PINS = 2'h1;
    localparam logic [6:0] ADDR = {`QDC_SLAVE_ADDR_TOP, SLV_PINS};
    // Rows: acknowledge expected, control, high byte, low byte
    localparam logic [24:0] ROWS [13] = '{
        {1'b1, 8'h40, 8'h12, 8'h3F}, {1'b1, 8'h42, 8'h34, 8'h5A},
        {1'b1, 8'h44, 8'h56, 8'h7C}, {1'b1, 8'h46, 8'h78, 8'h9E},
        {1'b1, 8'h52, 8'hFF, 8'hF0}, {1'b1, 8'h45, 8'hBF, 8'hFF},
        {1'b1, 8'h96, 8'h12, 8'h34}, {1'b0, 8'h52, 8'h00, 8'h00},
        {1'b1, 8'h60, 8'h00, 8'h10}, {1'b1, 8'h46, 8'h00, 8'h00},
        {1'b1, 8'h33, 8'hEE, 8'hEE}, {1'b1, 8'hF4, 8'h5A, 8'hA5},
        {1'b1, 8'h77, 8'h40, 8'h00}
    };
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    logic scl;
    logic sda_drv;
    logic sda_line;
    logic o_sda_out;
    logic o_sda_oe;
    logic i_load_strobe_pin = 1'b0;
    logic [1:0] i_readback_sel = 2'h0;
    logic [13:0] o_readback;
    logic [13:0] seen [4];
    logic [13:0] exp_temp [4] = '{default: 14'h0000};
    logic [13:0] exp_out [4] = '{default: 14'h0000};
    int bad_count = 0;
    int total_checks = 0;

    always #12.5 i_ref_clk = ~i_ref_clk;

    // Open-drain data line with pull-up: low if either side pulls
    assign sda_line = sda_drv & ((o_sda_oe === 1'b1) ? o_sda_out : 1'b1);

    qdc_bus_master qdc_bus_master_inst (
        .i_ref_clk(i_ref_clk),
        .i_sda_line(sda_line),
        .o_scl(scl),
        .o_sda(sda_drv)
    );

    qdc_ctrl qdc_ctrl_inst (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_scl(scl),
        .i_sda(sda_line),
        .o_sda_out(o_sda_out),
        .o_sda_oe(o_sda_oe),
        .i_slave_addr_pins(SLV_PINS),
        .i_ext_addr_pins(EXT_PINS),
        .i_load_strobe_pin(i_load_strobe_pin),
        .i_readback_sel(i_readback_sel),
        .o_readback(o_readback),
        .o_output_channel_a(seen[0]),
        .o_output_channel_b(seen[1]),
        .o_output_channel_c(seen[2]),
        .o_output_channel_d(seen[3])
    );

    // ==========================================================
    // Checking and closing
    task automatic tick(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask : tick

    task automatic check(input logic [13:0] got, input logic [13:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop

    // Outputs and readback of every channel against the expected stores
    task automatic check_all();
        for (int i = 0; i < 4; i++) begin
            check(seen[i], exp_out[i]);
            i_readback_sel = 2'(i);
            tick(1);
            check(o_readback, exp_temp[i]);
        end
    endtask : check_all

    // ==========================================================
    // Expected effect of one completed high and low byte pair
    task automatic model(input logic [7:0] c, input logic [7:0] hi, input logic [7:0] lo);
        logic [13:0] w;
        int s;
        w = c[0] ? {hi[7:6], 12'h000} : {2'b00, hi, lo[7:4]};
        s = int'(c[2:1]);
        if (c[5:4] == 2'b11) begin
            for (int i = 0; i < 4; i++) begin
                if (c[2]) begin
                    exp_temp[i] = w;
                end
                exp_out[i] = exp_temp[i];
            end
        end else if (c[7:6] == EXT_PINS) begin
            exp_temp[s] = w;
            if (c[5:4] == 2'b01) begin
                exp_out[s] = w;
            end
            if (c[5:4] == 2'b10) begin
                exp_out = exp_temp;
            end
        end
    endtask : model

    task automatic frame(input logic [6:0] addr, input logic [7:0] c, input logic [7:0] hi,
                         input logic [7:0] lo, input logic ack_exp);
        logic ack;
        logic [7:0] b [4];
        b = '{{addr, 1'b0}, c, hi, lo};
        qdc_bus_master_inst.start();
        for (int i = 0; i < 4; i++) begin
            qdc_bus_master_inst.put_byte(b[i], ack);
            check(14'(ack), 14'(ack_exp));
        end
        if (ack_exp) begin
            model(c, hi, lo);
        end
        qdc_bus_master_inst.stop();
        check_all();
    endtask : frame

    // Load pin raised only once the temporary stores hold their values
    task automatic pulse_load();
        i_load_strobe_pin = 1'b1;
        tick(6);
        i_load_strobe_pin = 1'b0;
        tick(6);
        exp_out = exp_temp;
        check_all();
    endtask : pulse_load

    // ==========================================================
    // Test sequence
    initial begin
        tick(8);
        i_rst = 1'b0;
        tick(6);
        check_all();
        $display("test reset done");
        for (int i = 0; i < 13; i++) begin
            if (i == 4) begin
                pulse_load();
                $display("test load pin done");
            end
            frame(ROWS[i][24] ? ADDR : ADDR ^ 7'h01, ROWS[i][23:16], ROWS[i][15:8],
                  ROWS[i][7:0], ROWS[i][24]);
            $display("test frame %0d done", i);
        end
        report_and_stop();
    end

    // Frames take some 300 cycles each; the limit leaves ample margin
    initial begin
        repeat (20000) @(posedge i_ref_clk);
        bad_count++;
        $display("watchdog expired at %0t", $time);
        report_and_stop();
    end

endmodule : qdc_ctrl_tb
